// ### bench/fast_ethernet_pcs_pma_coding_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin samplesChecked++; \
  if ((got) !== (want)) begin errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, want); \
  end end
module fast_ethernet_pcs_pma_coding_tb
  import fepc_pkg::*;
;
  logic mclk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rdv;
  logic [1:0]  bresp, rresp, rrs, brs;
  logic        txNibStb, txNrzi, rxNrzi = 0, rxSigDet = 1, rxLockOk = 1;
  logic        loop = 1, linBit = 1, clr = 0, txPrev = 0;
  logic [9:0]  txSh = 0;
  logic [3:0]  seen = 0;  // {crs, col, T R, J K}
  logic [3:0]  exp [$];
  fepcMiiTx_t  miiTx;
  fepcMiiRx_t  miiRx;
  int errors = 0, samplesChecked = 0, n, k, m;

  always #5 mclk = ~mclk;

  fepc_top i_dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .miiTx(miiTx), .txNibStb(txNibStb),
    .miiRx(miiRx), .txNrzi(txNrzi), .rxNrzi(rxNrzi), .rxSigDet(rxSigDet),
    .rxLockOk(rxLockOk));

  fepc_mac_model i_mac (.mclk(mclk), .txNibStb(txNibStb), .miiRx(miiRx),
    .miiTx(miiTx));

  // line loopback or driven symbols; decode the transmit line
  always @(posedge mclk) begin
    rxNrzi <= loop ? txNrzi : rxNrzi ^ linBit;
    txPrev <= txNrzi;
    txSh   <= {txSh[8:0], txNrzi ^ txPrev};
    seen   <= clr ? 4'h0 : seen | {miiRx.crs, miiRx.col,
              txSh == {CG_T, CG_R}, txSh == CG_JK};
  end

  // one write; response code kept in brs, a missing answer is a mismatch
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      brs = bresp;
    end while (!bvalid && n < 50);
    if (!bvalid) errors++;
    bready <= 0;
    @(posedge mclk);
  endtask : wr

  // one read; data and response kept in rdv and rrs
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 0;
      rdv = rdata;
      rrs = rresp;
    end while (!rvalid && n < 50);
    if (!rvalid) errors++;
    rready <= 0;
    @(posedge mclk);
  endtask : rd

  // clear the flags and the partner's logs
  task automatic fresh;
    clr <= 1; i_mac.rxQ = {}; i_mac.rxErrs = 0; exp = {};
    @(posedge mclk); clr <= 0;
  endtask : fresh

  // one frame through the loopback, error nibble at index er
  task automatic frame(input int len, input int er);
    logic [3:0] nb;
    fresh();
    for (int i = 0; i < 16 + len; i++) begin
      nb = i < 15 ? PRE_NIB : i == 15 ? 4'hd : 4'($urandom);
      if (i == er) nb = 4'h3;
      i_mac.txQ.push_back({i == er, nb});
      exp.push_back(nb);
    end
    k = 0;
    while (!(i_mac.txQ.size() == 0 && seen[1] && !miiRx.crs) && k < 3000) begin
      @(posedge mclk); k++;
    end
    if (k >= 3000) errors++;
    repeat (3) @(posedge mclk);
  endtask : frame

  task automatic line(input logic [39:0] v);
    fresh();
    for (int i = 39; i >= 0; i--) begin
      linBit <= v[i];
      @(posedge mclk);
    end
    linBit <= 1;
    repeat (20) @(posedge mclk);
  endtask : line

  task automatic closeOut;
    if (errors == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : closeOut

  // watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    closeOut();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    void'($urandom(98));
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    rd(OFS_CTRL); `CHK(rdv, 32'h0000_0000)
    rd(8'h0c); `CHK(rrs, RESP_SLVERR)
    rd(OFS_FAST); `CHK(rdv & 32'h0000_02e1, 32'h0000_0001)
    for (int i = 0; i < 4; i++) begin
      rxSigDet <= i[0]; rxLockOk <= i[1];
      @(posedge mclk);
      rd(OFS_STATUS); `CHK(rdv[STAT_LINK], i == 3)
      rd(OFS_FAST); `CHK(rdv[FS_LINK], i == 3)
      `CHK(rdv[FS_LOCK], i != 3)
    end
    for (m = 0; m < 2; m++) begin
      wr(OFS_CTRL, m);
      `CHK(brs, RESP_OKAY)
      frame(1 + $urandom % 12, -1);
      `CHK(i_mac.rxQ.size(), exp.size())
      foreach (exp[i]) `CHK(i_mac.rxQ[i], exp[i])
      `CHK(seen[1:0], 2'b11)
      `CHK(seen[2], m == 0)
      `CHK(i_mac.rxErrs, 0)
    end
    `CHK(seen[2], 1'b0)
    for (m = 0; m < 2; m++) begin
      wr(OFS_CTRL, m ? 32'h0000_0004 : 32'h0000_0000);
      `CHK(brs, RESP_OKAY)
      frame(8, 19);
      rd(OFS_FAST); `CHK(rdv[FS_INV], m == 1)
      `CHK(rdv[FS_HALT], m == 0)
      `CHK(i_mac.rxErrs != 0, 1'b1)
      `CHK(i_mac.rxQ[$], exp[$])
      rd(OFS_FAST); `CHK(rdv[FS_INV] | rdv[FS_HALT], 1'b0)
    end
    loop <= 0;
    for (m = 0; m < 3; m++) begin
      case (m)
        0: line({CG_I, CG_J, CG_K, 5'h0e, CG_T, CG_R, CG_I, CG_I});
        1: line({CG_I, CG_I, CG_J, CG_K, 5'h0e, CG_I, CG_I, CG_I});
        default: line({CG_I, CG_I, CG_I, 5'h0a, CG_I, CG_I, CG_I, CG_I});
      endcase
      `CHK(i_mac.rxQ.size(), m == 2 ? 0 : 3)
      if (m < 2) `CHK({i_mac.rxQ[0], i_mac.rxQ[2]}, 8'h56)
      `CHK(i_mac.rxErrs != 0, m != 0)
      `CHK({seen[3], miiRx.crs}, 2'b10)
      rd(OFS_FAST); `CHK(rdv[FS_PREM], m == 1)
    end
    closeOut();
  end
endmodule : fast_ethernet_pcs_pma_coding_tb
`default_nettype wire

// ### bench/fepc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************************************
// mac partner: sends queued nibbles, logs received nibbles
// ***********************************************************
module fepc_mac_model
  import fepc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       txNibStb,
  input  wire fepcMiiRx_t miiRx,
  output var  fepcMiiTx_t miiTx
);
  logic [4:0] txQ [$];  // {error, nibble} per strobe
  logic [3:0] rxQ [$];
  int         rxErrs;

  initial miiTx = '0;

  // next item right after the strobe that took the last one
  always @(posedge mclk) begin
    if (txNibStb && txQ.size() > 0) begin
      miiTx <= {1'b1, txQ.pop_front()};
    end else if (txNibStb) begin
      miiTx <= {2'b00, ~miiTx.txd};
    end
    if (miiRx.rxStb && miiRx.rxDv) begin
      rxQ.push_back(miiRx.rxd);
    end
    if (miiRx.rxStb && miiRx.rxEr) begin
      rxErrs++;
    end
  end
endmodule : fepc_mac_model
`default_nettype wire

// ### hdl/fepc_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - see: transmit nibbles become 5-bit code groups, sent serially onward.
// - see: first two preamble nibbles replaced by J then K.
// - see: when transmit enable drops, T then R follow the frame.
// - see: half duplex raises collision when sending and receiving together.
// - see: full duplex keeps collision low always.
// - see: transmit serial stream is NRZI coded before leaving.
// - see: idle line, two non-adjacent zeros start the delimiter search.
// - see: valid delimiter gives two preamble nibbles and sets group alignment.
// - see: aligned groups decode to nibbles delivered with a strobe.
// - see: decoding runs until end delimiter or idles; delimiter hidden.
// - see: a bad group raises receive error, then decoding continues.
// - see: idles before end delimiter raise error, premature bit, idle.
// - see: received line is NRZI decoded into plain bits.
// - see: lost clock lock sets a latching lock error bit.
// - see: no signal or lock error clears both link status bits.
// - see: carrier detect sets receiving and raises carrier sense.
// - see: delimiter not confirmed gives error, idle, carrier sense low.
// - see: confirmed idle, J, K moves the receiver into data receiving.
// - see: 16 data groups, six control groups, ten invalid groups.
// - see: an undefined group sets the invalid symbol bit.
// - see: a halt group sets the halt detected bit.
// - see: invalid groups sent only with enable bit and transmit error.
module fepc_top
  import fepc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire fepcMiiTx_t        miiTx,
  output logic                   txNibStb,
  output fepcMiiRx_t             miiRx,
  output logic                   txNrzi,
  input  wire logic              rxNrzi,
  input  wire logic              rxSigDet,
  input  wire logic              rxLockOk
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    fepcTxSt_t         txSt;
    logic [2:0]        divCnt;
    logic [4:0]        txShift;
    logic              txLine;
    fepcRxSt_t         rxSt;
    logic              rxPrev;
    logic [9:0]        rxWin;
    logic [2:0]        bitCnt;
    logic              prePend;
    logic              rxStb;
    logic              rxDv;
    logic              rxEr;
    logic [3:0]        rxd;
    logic              crs;
    logic              fdx;
    logic              txInv;
    logic              prem;
    logic              halt;
    logic              inv;
    logic              lock;
    logic [ADDR_W-1:0] awAddr;
    logic              awHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              wHave;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } fepcState_t;

  localparam fepcState_t ST_RESET = '{
    txSt: TX_IDLE, txShift: CG_I, rxSt: RX_IDLE, rxWin: 10'h3ff,
    fdx: CTRL_RESET[0], txInv: CTRL_RESET[1], default: '0};

  fepcState_t q;
  fepcState_t d;
  logic       txStb;
  logic       rxBit;
  logic [9:0] win;
  logic [4:0] grp;
  logic [4:0] dec;
  logic [4:0] code;
  logic       link;
  logic       setPrem;
  logic       setHalt;
  logic       setInv;
  logic       clrRead;
  logic [1:0] sel;
  logic [31:0] rval;

  // register select: 0 control, 1 status, 2 fast poll, 3 unmapped
  function automatic logic [1:0] regSel(input logic [ADDR_W-1:0] a);
    unique case ({a[ADDR_W-1:2], 2'b00})
      OFS_CTRL:   return 2'd0;
      OFS_STATUS: return 2'd1;
      OFS_FAST:   return 2'd2;
      default:    return 2'd3;
    endcase
  endfunction : regSel

  // two zero bits with at least one bit between them
  function automatic logic twoApart(input logic [9:0] w);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      for (int j = i + 2; j < 10; j++) begin
        if (!w[i] && !w[j]) begin
          r = 1'b1;
        end
      end
    end
    return r;
  endfunction : twoApart

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    d       = q;
    setPrem = 1'b0;
    setHalt = 1'b0;
    setInv  = 1'b0;
    clrRead = 1'b0;
    rval    = 32'h0000_0000;
    sel     = 2'd3;
    link    = rxSigDet && rxLockOk;

    // transmit: nibble divider, coding and serialiser
    txStb    = (q.divCnt == GRP_LAST);
    d.divCnt = txStb ? 3'h0 : q.divCnt + 3'h1;
    d.txLine = q.txLine ^ q.txShift[4];
    code     = CG_I;
    if (txStb) begin
      unique case (q.txSt)
        TX_IDLE: begin
          if (miiTx.txEn) begin
            code   = CG_J;
            d.txSt = TX_K;
          end
        end
        TX_K: begin
          code   = CG_K;
          d.txSt = TX_DATA;
        end
        TX_DATA: begin
          if (!miiTx.txEn) begin
            code   = CG_T;
            d.txSt = TX_R;
          end else if (miiTx.transmit_error_input && q.txInv) begin
            code   = {3'b000, miiTx.txd[1:0]};
          end else if (miiTx.transmit_error_input) begin
            code   = CG_H;
          end else begin
            code   = fepcEnc(miiTx.txd);
          end
        end
        TX_R: begin
          code   = CG_R;
          d.txSt = TX_IDLE;
        end
        default: d.txSt = TX_IDLE;
      endcase
      d.txShift = code;
    end else begin
      d.txShift = {q.txShift[3:0], 1'b1};
    end

    // receive: line decode, carrier, alignment and decoding
    rxBit    = rxNrzi ^ q.rxPrev;
    d.rxPrev = rxNrzi;
    win      = {q.rxWin[8:0], rxBit};
    d.rxWin  = win;
    grp      = win[4:0];
    dec      = fepcDec(grp);
    d.rxStb  = 1'b0;
    unique case (q.rxSt)
      RX_IDLE: begin
        d.bitCnt = 3'h0;
        if (twoApart(win)) begin
          d.crs  = 1'b1;
          d.rxSt = RX_CARR;
        end
      end
      RX_CARR: begin
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.bitCnt == JK_CHECK) begin
          d.bitCnt = 3'h0;
          d.rxStb  = 1'b1;
          if (win == CG_JK) begin
            d.rxSt    = RX_RECV;
            d.rxd     = PRE_NIB;
            d.rxDv    = 1'b1;
            d.rxEr    = 1'b0;
            d.prePend = 1'b1;
          end else begin
            d.rxSt = RX_IDLE;
            d.rxEr = 1'b1;
            d.crs  = 1'b0;
          end
        end
      end
      RX_RECV: begin
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.prePend && q.bitCnt == PRE2_SLOT) begin
          d.rxStb   = 1'b1;
          d.prePend = 1'b0;
        end
        if (q.bitCnt == GRP_LAST) begin
          d.bitCnt = 3'h0;
          d.rxStb  = 1'b1;
          d.rxEr   = 1'b0;
          if (grp == CG_T) begin
            d.rxSt = RX_END;
            d.rxDv = 1'b0;
          end else if (grp == CG_I) begin
            d.rxSt  = RX_IDLE;
            d.rxEr  = 1'b1;
            d.rxDv  = 1'b0;
            d.crs   = 1'b0;
            setPrem = 1'b1;
          end else if (dec[4]) begin
            d.rxd = dec[3:0];
          end else begin
            d.rxEr = 1'b1;
            if (grp == CG_H) begin
              setHalt = 1'b1;
            end else if (grp != CG_J && grp != CG_K && grp != CG_R) begin
              setInv = 1'b1;
            end
          end
        end
      end
      RX_END: begin
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.bitCnt == GRP_LAST) begin
          d.bitCnt = 3'h0;
          d.rxSt   = RX_IDLE;
          d.crs    = 1'b0;
          if (grp != CG_R) begin
            d.rxStb = 1'b1;
            d.rxEr  = 1'b1;
          end
        end
      end
      default: d.rxSt = RX_IDLE;
    endcase
    // back to idle: drop the frame's zeros so they raise no false carrier
    if (q.rxSt != RX_IDLE && d.rxSt == RX_IDLE) begin
      d.rxWin = 10'h3ff;
    end

    // bus write: address and data taken in either order
    if (s_axi_awvalid && !q.awHave && !q.bvalid) begin
      d.awAddr = s_axi_awaddr;
      d.awHave = 1'b1;
    end
    if (s_axi_wvalid && !q.wHave && !q.bvalid) begin
      d.wData  = s_axi_wdata;
      d.wStrb  = s_axi_wstrb;
      d.wHave  = 1'b1;
    end
    if (q.awHave && q.wHave) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = (regSel(q.awAddr) == 2'd3) ? RESP_SLVERR : RESP_OKAY;
      if (regSel(q.awAddr) == 2'd0 && q.wStrb[0]) begin
        d.fdx   = q.wData[CTRL_FDX];
        d.txInv = q.wData[CTRL_TXINV];
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // bus read: fast poll read clears its latched bits
    if (s_axi_arvalid && !q.rvalid) begin
      sel = regSel(s_axi_araddr);
      unique case (sel)
        2'd0: begin
          rval[CTRL_FDX]   = q.fdx;
          rval[CTRL_TXINV] = q.txInv;
        end
        2'd1: rval[STAT_LINK] = link;
        2'd2: begin
          rval[FS_LINK] = link;
          rval[FS_PREM] = q.prem;
          rval[FS_HALT] = q.halt;
          rval[FS_INV]  = q.inv;
          rval[FS_LOCK] = q.lock;
          clrRead       = 1'b1;
        end
        default: rval = 32'h0000_0000;
      endcase
      d.rvalid = 1'b1;
      d.rdata  = rval;
      d.rresp  = (sel == 2'd3) ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // latch_high bits: a new event wins over the read clear
    d.prem = (q.prem && !clrRead) || setPrem;
    d.halt = (q.halt && !clrRead) || setHalt;
    d.inv  = (q.inv && !clrRead) || setInv;
    d.lock = (q.lock && !clrRead) || !rxLockOk;
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign s_axi_awready = !q.awHave && !q.bvalid;
  assign s_axi_wready  = !q.wHave && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign txNibStb      = txStb;
  assign txNrzi        = q.txLine;
  assign miiRx.rxStb   = q.rxStb;
  assign miiRx.rxDv    = q.rxDv;
  assign miiRx.rxEr    = q.rxEr;
  assign miiRx.rxd     = q.rxd;
  assign miiRx.crs     = q.crs;
  // collision only in half duplex
  assign miiRx.col     = !q.fdx && q.txSt != TX_IDLE
                         && q.crs;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_COL_FDX: assert property (q.fdx |-> !miiRx.col)
    else $error("collision raised in full duplex");
  AST_COL_HDX: assert property (
    (!q.fdx && q.crs && q.txSt == TX_DATA) |-> miiRx.col)
    else $error("collision missing in half duplex");
  AST_TX_JK: assert property (
    (txStb && q.txSt == TX_IDLE && miiTx.txEn)
      |=> (q.txShift == CG_J) ##5 (q.txShift == CG_K))
    else $error("start delimiter not sent");
  AST_TX_TR: assert property (
    (txStb && q.txSt == TX_DATA && !miiTx.txEn)
      |=> (q.txShift == CG_T) ##5 (q.txShift == CG_R))
    else $error("end delimiter not sent");
  // the line step owed on the first edge out of reset is not checked
  AST_NRZI: assert property (
    $past(reset_n) |->
      ((q.txLine != $past(q.txLine)) == $past(q.txShift[4])))
    else $error("line transition does not match bit");
  AST_PREM: assert property (
    (q.rxSt == RX_RECV && q.bitCnt == GRP_LAST && grp == CG_I)
      |=> (q.prem && q.rxEr && !q.crs && q.rxSt == RX_IDLE))
    else $error("premature end not handled");
  AST_LOCK: assert property (!rxLockOk |=> q.lock [*2])
    else $error("lock error not latched");
  AST_CARR_FAIL: assert property (
    (q.rxSt == RX_CARR && q.bitCnt == JK_CHECK && win != CG_JK)
      |=> (!q.crs && q.rxEr && q.rxStb))
    else $error("bad delimiter not rejected");
  AST_END_HIDDEN: assert property (
    (q.rxSt == RX_END) |-> !q.rxDv)
    else $error("end delimiter forwarded");

  COV_TX_FRAME: cover property (q.txSt == TX_R);
  COV_RX_FRAME: cover property (q.rxSt == RX_RECV ##[1:200] q.rxSt == RX_END);
  COV_PREM: cover property (setPrem);
  COV_BUS_WR: cover property (q.bvalid && s_axi_bready);

endmodule : fepc_top
`default_nettype wire

// ### include/fepc_pkg.sv
`default_nettype none
package fepc_pkg;

  // ***********************************************************
  // bus map
  // ***********************************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00; // extended control
  localparam logic [7:0]  OFS_STATUS  = 8'h04; // basic status
  localparam logic [7:0]  OFS_FAST    = 8'h08; // fast_poll_status_register
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // field positions, numbered as in the device register map
  localparam int CTRL_FDX   = 0;  // full duplex select
  localparam int CTRL_TXINV = 2;  // transmit invalid codes enable
  localparam int STAT_LINK  = 2;  // link status
  localparam int FS_LINK    = 0;  // link status copy
  localparam int FS_PREM    = 5;  // premature end, latch_high
  localparam int FS_HALT    = 6;  // halt detected, latch_high
  localparam int FS_INV     = 7;  // invalid symbol, latch_high
  localparam int FS_LOCK    = 9;  // clock recovery lock error, latch_high

  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ***********************************************************
  // line coding
  // ***********************************************************
  localparam logic [2:0] GRP_LAST  = 3'h4;   // last bit of a code group
  localparam logic [2:0] JK_CHECK  = 3'h4;   // last K bit after carrier detect
  localparam logic [2:0] PRE2_SLOT = 3'h1;   // slot of second preamble
  localparam logic [3:0] PRE_NIB   = 4'h5;   // preamble nibble
  localparam logic [4:0] CG_I      = 5'h1f;
  localparam logic [4:0] CG_J      = 5'h18;
  localparam logic [4:0] CG_K      = 5'h11;
  localparam logic [4:0] CG_T      = 5'h0d;
  localparam logic [4:0] CG_R      = 5'h07;
  localparam logic [4:0] CG_H      = 5'h04;
  localparam logic [9:0] CG_JK     = 10'h311;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_K = 4'h2, TX_DATA = 4'h4, TX_R = 4'h8
  } fepcTxSt_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_CARR = 4'h2, RX_RECV = 4'h4, RX_END = 4'h8
  } fepcRxSt_t;

  // transmit side of the media independent interface
  typedef struct packed {
    logic       txEn;
    logic       transmit_error_input;     // transmit_error_input
    logic [3:0] txd;
  } fepcMiiTx_t;

  // receive side of the media independent interface
  typedef struct packed {
    logic       rxStb;    // one-cycle nibble strobe
    logic       rxDv;
    logic       rxEr;
    logic [3:0] rxd;
    logic       crs;
    logic       col;
  } fepcMiiRx_t;

  // nibble to code group
  function automatic logic [4:0] fepcEnc(input logic [3:0] nib);
    logic [4:0] t [16];
    t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
          5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    return t[nib];
  endfunction : fepcEnc

  // code group to {is data, nibble}
  function automatic logic [4:0] fepcDec(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (fepcEnc(4'(i)) == cg) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : fepcDec

endpackage : fepc_pkg
`default_nettype wire
